/* File: hw/csr_pkg.sv */
// constants and types for the charger supervisor and status reporter
package csr_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned NS_PER_US = 1000;
    // request strobe, reply delay and pulse period in ns
    localparam int unsigned REQ_LOW_MIN_NS = 200;
    localparam int unsigned REQ_LOW_MAX_NS = 10000;
    localparam int unsigned REPORT_DELAY_NS = 2000;
    localparam int unsigned PULSE_PERIOD_NS = 1000;
    // watchdog limits in minutes at the nominal timing capacitor
    localparam int unsigned TRICKLE_LIMIT_MIN = 25;
    localparam int unsigned FAST_LIMIT_MIN = 180;
    localparam int unsigned VOLT_LIMIT_MIN = 180;
    localparam int unsigned SECS_PER_MIN = 60;
    localparam int unsigned US_PER_SEC = 1000000;
    localparam int unsigned TICK_CYCLES_DEF = CLK_MHZ * US_PER_SEC;

    localparam int unsigned RPT_CNT_W = 13;
    localparam int unsigned WD_W = 16;
    localparam int unsigned CAP_W = 4;
    localparam int unsigned CODE_W = 5;

    // least times round up, longest times round down
    function automatic int unsigned ns_up(input int unsigned ns);
        return (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    endfunction
    function automatic int unsigned ns_dn(input int unsigned ns);
        return (ns * CLK_MHZ) / NS_PER_US;
    endfunction

    localparam logic [RPT_CNT_W-1:0] REQ_MIN_CYC = RPT_CNT_W'(ns_up(REQ_LOW_MIN_NS));
    localparam logic [RPT_CNT_W-1:0] REQ_MAX_CYC = RPT_CNT_W'(ns_dn(REQ_LOW_MAX_NS));
    localparam logic [RPT_CNT_W-1:0] DELAY_CYC = RPT_CNT_W'(ns_up(REPORT_DELAY_NS));
    localparam logic [RPT_CNT_W-1:0] HALF_CYC = RPT_CNT_W'(ns_dn(PULSE_PERIOD_NS) / 2);

    localparam logic [WD_W-1:0] TRICKLE_TICKS = WD_W'(TRICKLE_LIMIT_MIN * SECS_PER_MIN);
    localparam logic [WD_W-1:0] FAST_TICKS = WD_W'(FAST_LIMIT_MIN * SECS_PER_MIN);
    localparam logic [WD_W-1:0] VOLT_TICKS = WD_W'(VOLT_LIMIT_MIN * SECS_PER_MIN);

    // reply pulse counts
    localparam logic [CODE_W-1:0] RPT_DIE_OT = 5'h01;
    localparam logic [CODE_W-1:0] RPT_TEMP = 5'h02;
    localparam logic [CODE_W-1:0] RPT_OV = 5'h03;
    localparam logic [CODE_W-1:0] RPT_TRK_TO = 5'h05;
    localparam logic [CODE_W-1:0] RPT_TRK = 5'h06;
    localparam logic [CODE_W-1:0] RPT_FAST_TO = 5'h07;
    localparam logic [CODE_W-1:0] RPT_TLOOP = 5'h08;
    localparam logic [CODE_W-1:0] RPT_FAST = 5'h09;
    localparam logic [CODE_W-1:0] RPT_VOLT_TO = 5'h0a;
    localparam logic [CODE_W-1:0] RPT_VOLT = 5'h0b;
    localparam logic [CODE_W-1:0] RPT_DONE = 5'h0c;
    localparam logic [CODE_W-1:0] RPT_ERROR = 5'h17;

    typedef enum logic [2:0] {
        CSR_OFF = 3'b000,
        CSR_TRICKLE = 3'b001,
        CSR_FAST = 3'b010,
        CSR_VOLT = 3'b011,
        CSR_DONE = 3'b100
    } csr_phase_t;

    typedef enum logic [1:0] {
        RPT_IDLE = 2'b00,
        RPT_LOW = 2'b01,
        RPT_WAIT = 2'b10,
        RPT_SEND = 2'b11
    } csr_rpt_t;
endpackage

/* File: hw/csr_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module csr_sync #(
    parameter int unsigned W = 1
) (
    input wire logic ref_clk_i, // core clock
    input wire logic rst_i, // async reset, active high
    input wire logic [W-1:0] d_i, // asynchronous level
    output logic [W-1:0] q_o // synchronised level
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: hw/csr_tick.sv */
// divider giving a one-cycle enable every CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module csr_tick #(
    parameter int unsigned CYCLES = 4,
    parameter int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1
) (
    input wire logic ref_clk_i, // core clock
    input wire logic rst_i, // async reset, active high
    output logic tick_o // one-cycle enable
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else if (cnt_reg == W'(CYCLES - 1)) begin
            cnt_reg <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: hw/csr_top.sv */
// charger supervisor: watchdog, fault shutdown, lamps and status line
//
// What this block does
// - trickle phase over 25 minutes times out
// - trickle plus fast over 3 hours times out
// - voltage phase clears watchdog, 3 hours more
// - timeout periods scale with timing capacitor
// - grounded timing capacitor disables the watchdog
// - over-voltage halts charging until it clears
// - over-voltage shows fault lamps and report
// - die over-temperature shuts charging down
// - battery temperature fault: pass off, report, lamps
// - charging resumes once temperature fault clears
// - temperature checked before and during charging
// - temperature good only inside the window
// - lamp patterns for off, charging, done, fault
// - lamps are open-drain pull-downs
// - each idle-time request of 200 to 10000 ns answered by counted pulse burst
// - status line low-or-released, idles high
// - reply starts after report delay from release
// - reply pulses at the fixed pulse period
// - pulse counts map to the reported states
// - trickle, fast, voltage phase progression
`timescale 1ns/1ps
`default_nettype none
module csr_top
    import csr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = csr_pkg::TICK_CYCLES_DEF
) (
    input wire logic ref_clk_i, // 250 MHz core clock
    input wire logic rst_i, // async reset, active high
    input wire logic enable_i, // charger enable pin
    input wire logic adapter_input_ok_i, // adapter above lockout
    input wire logic battery_present_i, // cell connected
    input wire logic cell_above_min_i, // cell above preconditioning level
    input wire logic cell_at_reg_i, // cell reached regulation voltage
    input wire logic overvoltage_i, // cell above overvoltage_threshold
    input wire logic die_overtemp_i, // die above thermal limit
    input wire logic temp_above_low_i, // battery_temp_sense above temp_window_low
    input wire logic temp_below_high_i, // battery_temp_sense below temp_window_high
    input wire logic term_current_i, // current at termination level
    input wire logic thermal_loop_i, // thermal loop reducing current
    input wire logic below_recharge_i, // cell below recharge level
    input wire logic [csr_pkg::CAP_W-1:0] timing_cap_pin_i, // timing cap in nominal units, 0 = grounded
    input wire logic status_line_i, // status line level
    output logic status_line_o, // status line drive value, always low
    output logic status_line_oe_o, // status line pulled low
    output logic lamp_drive_one_o, // lamp one drive value, always low
    output logic lamp_drive_one_oe_o, // lamp one pulled low
    output logic lamp_drive_two_o, // lamp two drive value, always low
    output logic lamp_drive_two_oe_o, // lamp two pulled low
    output logic charge_on_o, // pass element on
    output logic wd_timeout_o // watchdog timed out
);
    localparam int unsigned NSYNC = 13 + CAP_W;
    localparam int HALF_I = int'(HALF_CYC);

    logic [NSYNC-1:0] pins_raw, pins_s;
    logic en_s, adp_s, bat_s, above_min_s, at_reg_s, ov_s, die_ot_s;
    logic t_lo_s, t_hi_s, term_s, tloop_s, rch_s, line_low_s;
    logic [CAP_W-1:0] cap_s;

    assign pins_raw = {enable_i, adapter_input_ok_i, battery_present_i, cell_above_min_i,
                       cell_at_reg_i, overvoltage_i, die_overtemp_i, temp_above_low_i,
                       temp_below_high_i, term_current_i, thermal_loop_i, below_recharge_i,
                       ~status_line_i, timing_cap_pin_i};
    // line synced as a low flag so the zero reset value matches the idle-high line
    assign {en_s, adp_s, bat_s, above_min_s, at_reg_s, ov_s, die_ot_s, t_lo_s,
            t_hi_s, term_s, tloop_s, rch_s, line_low_s, cap_s} = pins_s;

    csr_sync #(.W(NSYNC)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    logic sec_tick;

    csr_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_o(sec_tick)
    );

    csr_phase_t phase_reg;
    csr_rpt_t rpt_reg;
    logic expired_reg;
    logic [WD_W-1:0] wd_cnt_reg;
    logic [CAP_W-1:0] presc_reg;

    logic temp_ok, fault, supply_ok, charging, wd_en, wd_tick, wd_hit, go_volt;
    assign temp_ok = t_lo_s & t_hi_s;
    assign fault = ov_s | die_ot_s | ~temp_ok;
    assign supply_ok = en_s & adp_s & bat_s;
    // grounded timing pin turns watchdog off
    assign wd_en = (cap_s != '0);
    assign charging = supply_ok & ~fault & ~expired_reg
                      & (phase_reg inside {CSR_TRICKLE, CSR_FAST, CSR_VOLT});

    function automatic logic is_wd_hit(input csr_phase_t ph, input logic [WD_W-1:0] cnt);
        unique case (ph)
            CSR_TRICKLE: is_wd_hit = (cnt >= TRICKLE_TICKS);
            CSR_FAST: is_wd_hit = (cnt >= FAST_TICKS);
            CSR_VOLT: is_wd_hit = (cnt >= VOLT_TICKS);
            default: is_wd_hit = 1'b0;
        endcase
    endfunction

    assign wd_hit = wd_en & is_wd_hit(phase_reg, wd_cnt_reg);
    assign go_volt = charging & (phase_reg == CSR_FAST) & at_reg_s & ~wd_hit;

    // one watchdog count per cap units of seconds
    assign wd_tick = sec_tick & (presc_reg == cap_s - 1'b1);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            presc_reg <= '0;
        end else if (!wd_en || wd_tick) begin
            presc_reg <= '0;
        end else if (sec_tick) begin
            presc_reg <= presc_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= CSR_OFF;
        end else if (!supply_ok) begin
            phase_reg <= CSR_OFF;
        end else begin
            unique case (phase_reg)
                CSR_OFF: begin
                    // start only with a good temperature
                    if (!fault) begin
                        phase_reg <= above_min_s ? CSR_FAST : CSR_TRICKLE;
                    end
                end
                CSR_TRICKLE: begin
                    if (charging && !wd_hit && above_min_s) begin
                        phase_reg <= CSR_FAST;
                    end
                end
                CSR_FAST: begin
                    if (go_volt) begin
                        phase_reg <= CSR_VOLT;
                    end
                end
                CSR_VOLT: begin
                    if (charging && !wd_hit && term_s) begin
                        phase_reg <= CSR_DONE;
                    end
                end
                CSR_DONE: begin
                    // sleep until the cell sags, then reassess
                    if (rch_s) begin
                        phase_reg <= CSR_OFF;
                    end
                end
            endcase
        end
    end

    // count restarts on the voltage phase
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wd_cnt_reg <= '0;
        end else if (!supply_ok || phase_reg == CSR_OFF || phase_reg == CSR_DONE || go_volt) begin
            wd_cnt_reg <= '0;
        end else if (charging && wd_en && wd_tick && !wd_hit) begin
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
        end
    end

    // timeout latches until supply or enable drops
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            expired_reg <= 1'b0;
        end else if (!supply_ok) begin
            expired_reg <= 1'b0;
        end else if (charging && wd_hit) begin
            expired_reg <= 1'b1;
        end
    end

    // pass element follows fault state; resumes on clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            charge_on_o <= 1'b0;
            wd_timeout_o <= 1'b0;
        end else begin
            charge_on_o <= charging;
            wd_timeout_o <= expired_reg;
        end
    end

    // lamp encoding; no battery leaves both released
    // flashing without a cell comes from the pin capacitance, not from here
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lamp_drive_one_oe_o <= 1'b0;
            lamp_drive_two_oe_o <= 1'b0;
        end else if (!supply_ok) begin
            lamp_drive_one_oe_o <= 1'b0;
            lamp_drive_two_oe_o <= 1'b0;
        end else if (fault || expired_reg) begin
            // over-voltage and other faults light both
            lamp_drive_one_oe_o <= 1'b1;
            lamp_drive_two_oe_o <= 1'b1;
        end else begin
            lamp_drive_one_oe_o <= (phase_reg != CSR_DONE) && (phase_reg != CSR_OFF);
            lamp_drive_two_oe_o <= (phase_reg == CSR_DONE);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lamp_drive_one_o <= 1'b0;
            lamp_drive_two_o <= 1'b0;
            status_line_o <= 1'b0;
        end else begin
            lamp_drive_one_o <= 1'b0;
            lamp_drive_two_o <= 1'b0;
            status_line_o <= 1'b0;
        end
    end

    function automatic logic [CODE_W-1:0] status_code(
        input logic sup, input logic die, input logic tok, input logic ovp,
        input csr_phase_t ph, input logic exp, input logic tl);
        if (!sup) begin
            status_code = RPT_ERROR;
        end else if (die) begin
            status_code = RPT_DIE_OT;
        end else if (!tok) begin
            status_code = RPT_TEMP;
        end else if (ovp) begin
            status_code = RPT_OV;
        end else begin
            unique case (ph)
                CSR_TRICKLE: status_code = exp ? RPT_TRK_TO : RPT_TRK;
                CSR_FAST: status_code = exp ? RPT_FAST_TO : (tl ? RPT_TLOOP : RPT_FAST);
                CSR_VOLT: status_code = exp ? RPT_VOLT_TO : RPT_VOLT;
                CSR_DONE: status_code = RPT_DONE;
                default: status_code = RPT_ERROR;
            endcase
        end
    endfunction

    logic [CODE_W-1:0] status_now;
    // current state as a pulse count
    assign status_now = status_code(supply_ok, die_ot_s, temp_ok, ov_s, phase_reg, expired_reg, tloop_s);

    logic [RPT_CNT_W-1:0] rpt_cnt_reg;
    logic [CODE_W-1:0] code_reg, left_reg;
    logic strobe_ok;

    // overlong or short strobes draw no reply
    assign strobe_ok = (rpt_cnt_reg >= REQ_MIN_CYC) && (rpt_cnt_reg <= REQ_MAX_CYC);

    // strobe, delay, then burst of code pulses
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rpt_reg <= RPT_IDLE;
            rpt_cnt_reg <= '0;
            code_reg <= '0;
            left_reg <= '0;
            status_line_oe_o <= 1'b0;
        end else begin
            unique case (rpt_reg)
                RPT_IDLE: begin
                    if (line_low_s) begin
                        rpt_reg <= RPT_LOW;
                        rpt_cnt_reg <= RPT_CNT_W'(1);
                    end
                end
                RPT_LOW: begin
                    if (line_low_s) begin
                        if (rpt_cnt_reg <= REQ_MAX_CYC) begin
                            rpt_cnt_reg <= rpt_cnt_reg + 1'b1;
                        end
                    end else if (strobe_ok) begin
                        rpt_reg <= RPT_WAIT;
                        rpt_cnt_reg <= '0;
                        code_reg <= status_now;
                    end else begin
                        rpt_reg <= RPT_IDLE;
                    end
                end
                RPT_WAIT: begin
                    // hold off for the report delay
                    if (rpt_cnt_reg == DELAY_CYC - 1'b1) begin
                        rpt_reg <= RPT_SEND;
                        rpt_cnt_reg <= '0;
                        left_reg <= code_reg - 1'b1;
                        status_line_oe_o <= 1'b1;
                    end else begin
                        rpt_cnt_reg <= rpt_cnt_reg + 1'b1;
                    end
                end
                RPT_SEND: begin
                    // equal low and high halves per pulse
                    if (rpt_cnt_reg == HALF_CYC - 1'b1) begin
                        rpt_cnt_reg <= '0;
                        if (status_line_oe_o) begin
                            status_line_oe_o <= 1'b0;
                        end else if (left_reg == '0) begin
                            // trailing high half keeps bursts apart
                            rpt_reg <= RPT_IDLE;
                        end else begin
                            left_reg <= left_reg - 1'b1;
                            status_line_oe_o <= 1'b1;
                        end
                    end else begin
                        rpt_cnt_reg <= rpt_cnt_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    // helper for checks: pulses seen in the current burst
    logic [CODE_W-1:0] seen_reg;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            seen_reg <= '0;
        end else if (rpt_reg == RPT_WAIT) begin
            seen_reg <= '0;
        end else if (rpt_reg == RPT_SEND && $rose(status_line_oe_o)) begin
            seen_reg <= seen_reg + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    AST_TRICKLE_LIMIT: assert property (
        charging && phase_reg == CSR_TRICKLE && wd_en && wd_cnt_reg >= TRICKLE_TICKS
        |=> expired_reg ##1 !charge_on_o)
        else $error("trickle limit did not stop charging");
    AST_FAST_LIMIT: assert property (
        charging && phase_reg == CSR_FAST && wd_en && wd_cnt_reg >= FAST_TICKS
        |=> expired_reg && phase_reg == CSR_FAST)
        else $error("fast limit did not time out");
    AST_VOLT_CLEAR: assert property (
        go_volt |=> phase_reg == CSR_VOLT && wd_cnt_reg == '0)
        else $error("watchdog not cleared entering voltage phase");
    AST_WD_STEP: assert property (
        $changed(wd_cnt_reg) && wd_cnt_reg != '0 |-> $past(wd_tick) && $past(sec_tick))
        else $error("watchdog stepped off its scaled tick");
    AST_WD_DISABLED: assert property (
        !wd_en && !expired_reg |=> !expired_reg)
        else $error("watchdog fired with grounded timing pin");
    AST_OV_HALT: assert property (
        ov_s |=> !charge_on_o)
        else $error("charging during over-voltage");
    AST_OV_REPORT: assert property (
        supply_ok && ov_s && !die_ot_s && temp_ok |-> status_now == RPT_OV)
        else $error("over-voltage not reported");
    AST_DIE_HALT: assert property (
        die_ot_s |=> !charge_on_o)
        else $error("charging during die over-temperature");
    AST_TEMP_LAMPS: assert property (
        supply_ok && !temp_ok |=> lamp_drive_one_oe_o && lamp_drive_two_oe_o && !charge_on_o)
        else $error("temperature fault not shown");
    AST_DONE_LAMPS: assert property (
        supply_ok && !fault && !expired_reg && phase_reg == CSR_DONE
        |=> !lamp_drive_one_oe_o && lamp_drive_two_oe_o)
        else $error("wrong lamps for end of charge");
    AST_OPEN_DRAIN: assert property (
        !lamp_drive_one_o && !lamp_drive_two_o && !status_line_o)
        else $error("pin driven high");
    AST_REPORT_DELAY: assert property (
        rpt_reg == RPT_WAIT && rpt_cnt_reg < DELAY_CYC - 1'b1 |=> !status_line_oe_o)
        else $error("reply started before the report delay");
    AST_PULSE_WIDTH: assert property (
        $rose(status_line_oe_o) |-> ##HALF_I !status_line_oe_o)
        else $error("reply pulse width wrong");
    AST_PULSE_COUNT: assert property (
        rpt_reg == RPT_SEND ##1 rpt_reg == RPT_IDLE |-> seen_reg == code_reg)
        else $error("burst length differs from code");
    AST_PRIORITY: assert property (
        supply_ok && die_ot_s |-> status_now == RPT_DIE_OT)
        else $error("die fault not given first place");

    COV_DONE_REPORT: cover property (rpt_reg == RPT_WAIT && code_reg == RPT_DONE);
    COV_TIMEOUT: cover property ($rose(expired_reg));
    COV_OV_RESUME: cover property (ov_s && phase_reg == CSR_FAST ##1 !ov_s [*2] ##1 charge_on_o);
    COV_FULL_BURST: cover property (rpt_reg == RPT_SEND ##1 rpt_reg == RPT_IDLE);
endmodule
`default_nettype wire

/* File: testbench/csr_host_model.sv */
// host model that strobes the status line and counts reply pulses
`timescale 1ns/1ps
`default_nettype none
module csr_host_model (
    input wire logic ref_clk_i, // core clock
    input wire logic line_i, // resolved line level
    output logic drive_low_o // host pulls line low
);
    initial drive_low_o = 1'b0;
    task automatic request(input int len, output int n);
        int quiet;
        logic prev;
        n = 0;
        quiet = 0;
        prev = 1'b1;
        @(negedge ref_clk_i) drive_low_o = 1'b1;
        repeat (len) @(negedge ref_clk_i);
        drive_low_o = 1'b0;
        // quiet bound must outlast the reply delay
        while (quiet < 700) begin
            @(negedge ref_clk_i);
            if (prev && !line_i) n++;
            quiet = line_i ? quiet + 1 : 0;
            prev = line_i;
        end
    endtask
endmodule
`default_nettype wire

/* File: testbench/test_csr_top.sv */
// self-checking bench for the charger supervisor
`timescale 1ns/1ps
`default_nettype none
module test_csr_top;
    import csr_pkg::*;
    localparam logic [11:0] SUP = 12'h187;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] c = 12'h000;
    logic [11:0] v;
    logic [CAP_W-1:0] cap = 4'h0;
    logic [31:0] seed = 32'hde51;
    logic oe, host_low, on, wd_to, l1, l2, d0, d1, d2;
    int n_errors = 0;
    int n_checks = 0;
    int n;
    wire logic line = !(oe || host_low);
    csr_top #(.TICK_CYCLES(4)) dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .enable_i(c[0]), .adapter_input_ok_i(c[1]),
        .battery_present_i(c[2]), .cell_above_min_i(c[3]), .cell_at_reg_i(c[4]), .overvoltage_i(c[5]),
        .die_overtemp_i(c[6]), .temp_above_low_i(c[7]), .temp_below_high_i(c[8]), .term_current_i(c[9]),
        .thermal_loop_i(c[10]), .below_recharge_i(c[11]), .timing_cap_pin_i(cap), .status_line_i(line),
        .status_line_o(d0), .status_line_oe_o(oe), .lamp_drive_one_o(d1), .lamp_drive_one_oe_o(l1),
        .lamp_drive_two_o(d2), .lamp_drive_two_oe_o(l2), .charge_on_o(on), .wd_timeout_o(wd_to));
    csr_host_model host (.ref_clk_i(ref_clk_i), .line_i(line), .drive_low_o(host_low));
    initial forever #2 ref_clk_i = ~ref_clk_i;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // missing supply gives the error count, then lowest count wins, fast phase assumed
    function automatic logic [CODE_W-1:0] exp_code(input logic [11:0] x);
        if (!(x[0] && x[1] && x[2])) return RPT_ERROR;
        if (x[6]) return RPT_DIE_OT;
        if (!(x[7] && x[8])) return RPT_TEMP;
        if (x[5]) return RPT_OV;
        return RPT_FAST;
    endfunction
    task automatic complete_run();
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic rpt(input logic [CODE_W-1:0] e);
        seed = xs(seed);
        host.request(60 + int'(seed % 1000), n);
        chk("pulses", 8'(e), 8'(n));
    endtask
    task automatic set(input logic [11:0] x);
        @(negedge ref_clk_i) c = x;
        repeat (10) @(negedge ref_clk_i);
    endtask
    task automatic outs(input logic [1:0] lamps, input logic chg);
        chk("lamps", 8'(lamps), 8'({l1, l2}));
        chk("charge_on", 8'(chg), 8'(on));
        chk("drive_values", 8'h00, 8'({d0, d1, d2}));
    endtask
    task automatic wd(input logic [CAP_W-1:0] k);
        int i;
        set(12'h000);
        cap = k;
        set(SUP);
        i = 10;
        while (wd_to !== 1'b1 && i < 20000) begin
            @(negedge ref_clk_i);
            i++;
        end
        if (i >= 20000) begin
            n_errors++;
            complete_run();
        end
        chk("wd_time", 8'h01, 8'(i > 6000 * k - 24 && i < 6000 * k + 24));
        rpt(RPT_TRK_TO);
        outs(2'b11, 1'b0);
    endtask
    initial begin
        repeat (8) @(negedge ref_clk_i);
        rst_i = 1'b0;
        outs(2'b00, 1'b0);
        host.request(20, n);
        chk("short_strobe", 8'h00, 8'(n));
        set(SUP);
        outs(2'b10, 1'b1);
        rpt(RPT_TRK);
        repeat (7000) @(negedge ref_clk_i);
        chk("wd_off", 8'h00, 8'(wd_to));
        set(SUP | 12'h008);
        rpt(RPT_FAST);
        set(SUP | 12'h408);
        rpt(RPT_TLOOP);
        // random fault mixes in fast phase
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            v = (SUP | 12'h008) ^ (seed[11:0] & 12'h1e0);
            set(v);
            rpt(exp_code(v));
            outs((v == (SUP | 12'h008)) ? 2'b10 : 2'b11, v == (SUP | 12'h008));
        end
        set(SUP | 12'h008);
        rpt(RPT_FAST);
        set(SUP | 12'h018);
        rpt(RPT_VOLT);
        set(SUP | 12'h218);
        rpt(RPT_DONE);
        outs(2'b01, 1'b0);
        set(12'h000);
        rpt(RPT_ERROR);
        outs(2'b00, 1'b0);
        wd(4'h1);
        wd(4'h2);
        complete_run();
    end
endmodule
`default_nettype wire
